// >>> rtl/bbse_exec.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module bbse_exec
	import bbse_pkg::*;
#(
	parameter int PC_W   = 21,
	parameter int ADDR_W = 12,
	parameter int BANK_W = 4
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [15:0]       instr,
	input  wire logic [PC_W-1:0]   instr_addr,
	input  wire logic [ADDR_W-1:0] index_base,
	output logic                   cycle_start,
	output logic                   pc_load,
	output logic [PC_W-1:0]        pc_target,
	output logic                   flush,
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic [ADDR_W-1:0]      mem_addr,
	input  wire logic [7:0]        mem_rdata,
	output logic [7:0]             mem_wdata,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic [15:0]            reg_rdata
);
	bbse_phase_if ph ();

	bbse_qphase u_qphase (
		.clk (clk),
		.rst (rst),
		.ph  (ph.src)
	);

	bbse_op_type         op_q;
	bbse_op_type         op_d;
	logic [PC_W-1:0]     target_q;
	logic [PC_W-1:0]     target_d;
	logic [ADDR_W-1:0]   addr_q;
	logic [ADDR_W-1:0]   addr_d;
	logic [2:0]          bit_idx_q;
	logic [7:0]          wdata_q;
	logic [BANK_W-1:0]   bank_q;
	logic                ext_en_q;
	logic                indexed_q;
	logic [15:0]         rdata_q;

	// field extraction
	wire logic           is_jump;
	wire logic           is_bitset;
	wire logic [10:0]    jump_ofs;
	wire logic [2:0]     bit_idx;
	wire logic           asel;
	wire logic [7:0]     file_addr;
	wire logic [PC_W-1:0] ofs_x2;
	wire logic [PC_W-1:0] jump_dest;
	wire logic           use_index;
	wire logic [ADDR_W-1:0] access_addr;
	wire logic [ADDR_W-1:0] banked_addr;
	wire logic [ADDR_W-1:0] index_addr;
	wire logic [7:0]     set_mask;

	assign is_jump   = (instr[15:11] == OPC_JUMP);
	assign is_bitset = (instr[15:12] == OPC_BITSET);
	assign jump_ofs  = instr[JUMP_OFS_MSB:0];
	assign bit_idx   = instr[BIT_IDX_LSB+2:BIT_IDX_LSB];
	assign asel      = instr[ASEL_BIT];
	assign file_addr = instr[7:0];

	// sign extended and doubled, so the range is -2048..+2046 bytes
	assign ofs_x2    = {{(PC_W-12){jump_ofs[10]}}, jump_ofs, 1'b0};
	// instr_addr is the address of the jump itself; +2 stands for the prefetch step
	assign jump_dest = instr_addr + PC_W'(PC_STEP) + ofs_x2;

	assign use_index   = !asel && ext_en_q && (file_addr <= INDEX_LIMIT);
	assign access_addr = (file_addr < ACCESS_SPLIT) ?
		{{(ADDR_W-8){1'b0}}, file_addr} :
		{ACCESS_HI_BANK, file_addr};
	assign banked_addr = {bank_q, file_addr};
	assign index_addr  = index_base + {{(ADDR_W-8){1'b0}}, file_addr};

	// decode happens only at Q1; a jump forces the next slot to a no-operation
	always_comb begin
		op_d     = op_q;
		target_d = target_q;
		addr_d   = addr_q;
		if (ph.q1) begin
			case (op_q)
				OP_JUMP: begin
					op_d = OP_FLUSH;
				end
				OP_NONE,
				OP_BITSET,
				OP_FLUSH: begin
					if (is_jump) begin
						op_d     = OP_JUMP;
						target_d = jump_dest;
					end else if (is_bitset) begin
						op_d = OP_BITSET;
						if (use_index) begin
							addr_d = index_addr;
						end else if (asel) begin
							addr_d = banked_addr;
						end else begin
							addr_d = access_addr;
						end
					end else begin
						op_d = OP_NONE;
					end
				end
				default: begin
					op_d = OP_NONE;
				end
			endcase
		end
	end

	assign set_mask = 8'h01 << bit_idx_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_q      <= OP_NONE;
			target_q  <= '0;
			addr_q    <= '0;
			bit_idx_q <= 3'h0;
			indexed_q <= 1'b0;
		end else begin
			op_q     <= op_d;
			target_q <= target_d;
			addr_q   <= addr_d;
			// a word dropped in the flush slot must not touch these
			if (ph.q1 && op_d == OP_BITSET) begin
				bit_idx_q <= bit_idx;
				indexed_q <= use_index;
			end
		end
	end

	// modify in Q3: read data arrives the cycle after the Q2 strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdata_q <= 8'h00;
		end else if (ph.q3 && op_q == OP_BITSET) begin
			wdata_q <= mem_rdata | set_mask;
		end
	end

	assign cycle_start = ph.q1;
	assign pc_load     = ph.q4 && (op_q == OP_JUMP);
	assign pc_target   = target_q;
	// flush spans Q1..Q4 of the dropped slot, not the next decode
	assign flush       = ph.q1 ? (op_q == OP_JUMP) : (op_q == OP_FLUSH);
	assign mem_rd      = ph.q2 && (op_q == OP_BITSET);
	assign mem_wr      = ph.q4 && (op_q == OP_BITSET);
	assign mem_addr    = addr_q;
	assign mem_wdata   = wdata_q;

	// software side: bank select and extended-set enable steer addressing
	wire logic        wr_bank;
	wire logic        wr_ctrl;
	wire logic [15:0] status_word;
	wire logic [15:0] rd_mux;
	wire logic [31:0] target_wide;

	assign wr_bank     = reg_we && (reg_addr == REG_BANK_SEL);
	assign wr_ctrl     = reg_we && (reg_addr == REG_CTRL);
	assign status_word = {12'h000, indexed_q, flush, op_q};
	assign target_wide = 32'(target_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_q   <= BANK_SEL_RST;
			ext_en_q <= EXT_EN_RST;
		end else begin
			if (wr_bank) begin
				bank_q <= reg_wdata[BANK_W-1:0];
			end
			if (wr_ctrl) begin
				ext_en_q <= reg_wdata[CTRL_EXT_BIT];
			end
		end
	end

	assign rd_mux =
		(reg_addr == REG_BANK_SEL)  ? 16'(bank_q) :
		(reg_addr == REG_CTRL)      ? 16'(ext_en_q) :
		(reg_addr == REG_STATUS)    ? status_word :
		(reg_addr == REG_TARGET_LO) ? target_wide[15:0] :
		(reg_addr == REG_TARGET_HI) ? target_wide[31:16] :
		(reg_addr == REG_LAST_ADDR) ? 16'(addr_q) :
		16'h0000;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (reg_re) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_q;
endmodule : bbse_exec

// >>> include/bbse_pkg.sv
package bbse_pkg;

	localparam logic [4:0] OPC_JUMP       = 5'h1A;
	localparam logic [3:0] OPC_BITSET     = 4'h8;
	localparam int         JUMP_OFS_MSB   = 10;
	localparam int         BIT_IDX_LSB    = 9;
	localparam int         ASEL_BIT       = 8;
	localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] INDEX_LIMIT    = 8'h5F;
	localparam int         PC_STEP        = 2;

	localparam logic [3:0] REG_BANK_SEL   = 4'h0;
	localparam logic [3:0] REG_CTRL       = 4'h1;
	localparam logic [3:0] REG_STATUS     = 4'h2;
	localparam logic [3:0] REG_TARGET_LO  = 4'h3;
	localparam logic [3:0] REG_TARGET_HI  = 4'h4;
	localparam logic [3:0] REG_LAST_ADDR  = 4'h5;

	localparam logic [3:0] BANK_SEL_RST   = 4'h0;
	localparam logic       EXT_EN_RST     = 1'b0;
	localparam int         CTRL_EXT_BIT   = 0;

	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_JUMP   = 2'b01,
		OP_BITSET = 2'b10,
		OP_FLUSH  = 2'b11
	} bbse_op_type;

endpackage : bbse_pkg

// >>> include/bbse_phase_if.sv
`timescale 1ns/1ps
interface bbse_phase_if;
	logic q1;
	logic q2;
	logic q3;
	logic q4;

	modport src (
		output q1,
		output q2,
		output q3,
		output q4
	);

	modport snk (
		input q1,
		input q2,
		input q3,
		input q4
	);
endinterface : bbse_phase_if

// >>> rtl/bbse_qphase.sv
`timescale 1ns/1ps
module bbse_qphase
	import bbse_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	bbse_phase_if.src ph
);
	logic [1:0] phase_q;
	logic [1:0] phase_d;

	// four clocks make one instruction cycle, one enable per quarter
	assign phase_d = phase_q + 2'h1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign ph.q1 = (phase_q == 2'h0);
	assign ph.q2 = (phase_q == 2'h1);
	assign ph.q3 = (phase_q == 2'h2);
	assign ph.q4 = (phase_q == 2'h3);
endmodule : bbse_qphase

// >>> dv/bbse_chk.sv
`timescale 1ns/1ps
module bbse_chk
	import bbse_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [15:0]       instr,
	input wire logic              cycle_start,
	input wire logic              pc_load,
	input wire logic              flush,
	input wire logic              mem_rd,
	input wire logic              mem_wr,
	input wire logic [ADDR_W-1:0] mem_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// a word offered in the flush cycle must not count as decoded
	wire jmp  = cycle_start && !flush && instr[15:11] == OPC_JUMP;
	wire bset = cycle_start && !flush && instr[15:12] == OPC_BITSET;

	sequence s_flush;
		flush[*4] ##1 !flush;
	endsequence
	sequence s_rmw;
		mem_rd ##1 !mem_rd && !mem_wr ##1 mem_wr && $stable(mem_addr) ##1 !mem_wr;
	endsequence

	property p_jump;
		jmp |=> !pc_load[*2] ##1 pc_load ##1 s_flush;
	endproperty
	property p_load_src;
		pc_load |-> $past(jmp, 3);
	endproperty
	property p_flush_src;
		$rose(flush) |-> $past(pc_load);
	endproperty
	property p_bset;
		bset |=> s_rmw;
	endproperty
	property p_rd_src;
		mem_rd |-> $past(bset);
	endproperty
	property p_wr_src;
		mem_wr |-> $past(mem_rd, 2);
	endproperty
	property p_phase;
		cycle_start |=> !cycle_start[*3] ##1 cycle_start;
	endproperty
	property p_noflush;
		bset |=> !flush[*4];
	endproperty

	a_jump: assert property (p_jump) else $error("jump timing wrong");
	a_load_src: assert property (p_load_src) else $error("pc load without jump");
	a_flush_src: assert property (p_flush_src) else $error("flush without pc load");
	a_bset: assert property (p_bset) else $error("bit set sequence wrong");
	a_rd_src: assert property (p_rd_src) else $error("read without bit set");
	a_wr_src: assert property (p_wr_src) else $error("write without read");
	a_phase: assert property (p_phase) else $error("cycle start period wrong");
	a_noflush: assert property (p_noflush) else $error("flush after bit set");
endmodule : bbse_chk

// >>> dv/bbse_mem_model.sv
`timescale 1ns/1ps
module bbse_mem_model #(
	parameter int ADDR_W = 12
) (
	input wire logic              clk,
	input wire logic              mem_rd,
	input wire logic              mem_wr,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [7:0]        mem_wdata,
	output logic [7:0]            mem_rdata
);
	logic [7:0] ram [2**ADDR_W];
	logic       rd_q = 1'h0;

	// plain always: the bench preloads cells of ram directly
	always @(posedge clk) begin
		rd_q <= mem_rd;
		if (mem_wr) begin
			ram[mem_addr] <= mem_wdata;
		end
	end
	// outside the read slot the bus shows garbage, not the last value
	assign mem_rdata = rd_q ? ram[mem_addr] : ~ram[mem_addr];
endmodule : bbse_mem_model

// >>> dv/bbse_exec_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module bbse_exec_bench;
	logic        clk = 1'h0, rst = 1'h1, reg_we = 1'h0, reg_re = 1'h0;
	logic [15:0] instr = 16'h0, reg_wdata = 16'h0, reg_rdata;
	logic [20:0] instr_addr = 21'h0, pc_target, tgt;
	logic [11:0] index_base = 12'h200, mem_addr, ma;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  mem_rdata, mem_wdata, wd;
	logic        cycle_start, pc_load, flush, mem_rd, mem_wr, ld, wr, rd;
	int          error_cnt = 0, n_tests = 0, cyc = 0, nf, nr;

	bbse_exec dut (.clk, .rst, .instr, .instr_addr, .index_base, .cycle_start, .pc_load,
		.pc_target, .flush, .mem_rd, .mem_wr, .mem_addr, .mem_rdata, .mem_wdata, .reg_addr,
		.reg_wdata, .reg_we, .reg_re, .reg_rdata);
	bbse_mem_model mem (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

	initial forever #5 clk = ~clk;

	task automatic end_sim;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'h0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_re <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'h0;
		#1;
		d = reg_rdata;
	endtask : reg_rd

	// issues w, then offers a bit set in the following slot to see if it is dropped
	task automatic run(input logic [15:0] w, input logic [20:0] a);
		do begin
			@(posedge clk);
			#1;
		end while (cycle_start !== 1'h1);
		repeat (4) @(posedge clk);
		instr <= w;
		instr_addr <= a;
		@(posedge clk);
		#1;
		tgt = pc_target;
		rd = mem_rd;
		ma = mem_addr;
		repeat (2) @(posedge clk);
		#1;
		ld = pc_load;
		wr = mem_wr;
		wd = mem_wdata;
		nf = 0;
		nr = 0;
		@(posedge clk);
		instr <= 16'h8000;
		repeat (4) begin
			#1;
			nf += (flush === 1'h1);
			nr += (mem_rd === 1'h1);
			@(posedge clk);
			instr <= 16'h0;
		end
	endtask : run

	task automatic test_jump;
		logic [10:0] ofs [4] = '{11'h3FF, 11'h400, 11'h000, 11'h7FF};
		foreach (ofs[i]) begin
			run({5'h1A, ofs[i]}, 21'h01000);
			`CHK("target", 21'h01002 + {{9{ofs[i][10]}}, ofs[i], 1'h0}, tgt)
			`CHK("jump", 4'h8, {ld, rd, wr, nr[0]})
			`CHK("flush", 4, nf)
		end
		run(16'hD800, 21'h01000);
		`CHK("no jump", 4'h0, {ld, nf[2:0]})
	endtask : test_jump

	task automatic test_bitset;
		logic [15:0] w [6] = '{16'h8E55, 16'h8090, 16'h8734, 16'h845F, 16'h8A60, 16'h8310};
		logic [11:0] ea [6] = '{12'h055, 12'hF90, 12'h534, 12'h25F, 12'h060, 12'h510};
		logic [15:0] d;
		reg_wr(4'h0, 16'h0005);
		reg_rd(4'h0, d);
		`CHK("bank", 16'h0005, d)
		reg_rd(4'hF, d);
		`CHK("unmapped", 16'h0000, d)
		foreach (w[i]) begin
			reg_wr(4'h1, {15'h0, i > 2});
			mem.ram[ea[i]] = 8'h0A;
			run(w[i], 21'h0);
			`CHK("addr", ea[i], ma)
			`CHK("data", 8'h0A | (8'h01 << w[i][11:9]), wd)
			`CHK("ram", 8'h0A | (8'h01 << w[i][11:9]), mem.ram[ea[i]])
			`CHK("one cycle", 4'hF, {rd, wr, nf == 0, nr == 1})
		end
	endtask : test_bitset

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		test_jump();
		$display("jump test done");
		test_bitset();
		$display("bit set test done");
		end_sim();
	end
endmodule : bbse_exec_bench

bind bbse_exec bbse_chk #(.ADDR_W(ADDR_W)) chk (.clk, .rst, .instr, .cycle_start, .pc_load,
	.flush, .mem_rd, .mem_wr, .mem_addr);
